// ---- core/tcg_pkg.sv ----
`default_nettype none
package tcg_pkg;
	// generator run modes
	typedef enum logic [1:0] {
		GENERATOR_RUN_MODE_RUN,
		GENERATOR_RUN_MODE_TRACK,
		GENERATOR_RUN_MODE_JAM,
		GENERATOR_RUN_MODE_HOLD
	} generator_run_mode_t;

	typedef struct packed {
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
		logic [4:0] frames;
	} tcg_time_t;

	localparam logic [4:0] TCG_HOURS_MAX = 5'h17;
	localparam logic [5:0] TCG_MINSEC_MAX = 6'h3b;
	localparam logic [4:0] TCG_FRAME_RATE_DEF = 5'h1e;
	localparam logic [4:0] TCG_DROP_COUNT = 5'h02;
	localparam logic [3:0] TCG_DROP_SKIP_DIV = 4'ha;
	localparam tcg_time_t TCG_TIME_RESET = '0;
	// line pair selector 0 = off, 1..7 = first line 13..19, second line two later
	localparam logic [4:0] TCG_INS_BASE_LINE = 5'h0c;
	localparam logic [4:0] TCG_PAIR_GAP = 5'h02;
	localparam logic [4:0] TCG_REF_LINE_MIN = 5'h0c;
	localparam logic [4:0] TCG_REF_LINE_MAX = 5'h15;
	// aux output sources
	localparam logic [3:0] TCG_AUX_SRC_LTC = 4'h0;
	localparam int TCG_AUX_COUNT = 3;
endpackage
`default_nettype wire

// ---- core/tcg_ltc_ser.sv ----
`timescale 1ns/10ps
`default_nettype none
// biphase-mark serialiser of the 80-bit linear timecode word
module tcg_ltc_ser (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// control
	input wire logic frame_tick,
	input wire logic bit_tick,
	input wire tcg_pkg::tcg_time_t tc,
	// line
	output logic ltc_out
);
	localparam logic [15:0] SYNC_WORD = 16'hbffc;
	logic [79:0] sh_q, sh_d;
	logic lvl_q, lvl_d;
	logic half_q, half_d;

	function automatic logic [7:0] bcd8(input logic [6:0] v);
		bcd8 = {1'b0, 3'(v / 7'h0a), 4'(v % 7'h0a)};
	endfunction

	always_comb begin
		logic [7:0] f, s, m, h;
		f = bcd8({2'h0, tc.frames});
		s = bcd8({1'b0, tc.seconds});
		m = bcd8({1'b0, tc.minutes});
		h = bcd8({2'h0, tc.hours});
		sh_d = sh_q;
		lvl_d = lvl_q;
		half_d = half_q;
		if (frame_tick) begin
			sh_d = {SYNC_WORD, 4'h0, 2'h0, h[5:4], 4'h0, h[3:0], 4'h0, 1'b0, m[6:4],
				4'h0, m[3:0], 4'h0, 1'b0, s[6:4], 4'h0, s[3:0], 4'h0, 2'h0, f[5:4],
				4'h0, f[3:0]};
			half_d = 1'b0;
		end else if (bit_tick) begin
			if (!half_q) begin
				lvl_d = ~lvl_q;
			end else begin
				if (sh_q[0]) begin
					lvl_d = ~lvl_q;
				end
				sh_d = {1'b0, sh_q[79:1]};
			end
			half_d = ~half_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sh_q <= '0;
			lvl_q <= 1'b0;
			half_q <= 1'b0;
		end else begin
			sh_q <= sh_d;
			lvl_q <= lvl_d;
			half_q <= half_d;
		end
	end

	assign ltc_out = lvl_q;
endmodule // tcg_ltc_ser
`default_nettype wire

// ---- core/tcg_timecode_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - after reset the count is 0:0:0:0 and then counts onward
// - a preset strobe loads the written time; counting continues from it
// - hours held to 0..23, minutes and seconds to 0..59
// - track mode copies decoded reference timecode into the count each frame
// - run mode is one of run, track, jam once, hold
// - drop frame skips frames 0 and 1 each minute except every tenth
// - composite timecode on selectable line pair 13/15..19/21, or off
// - serial digital timecode on selectable line pair 13/15..19/21, or off
// - reference line strobe on one selectable line 12..21; reference time taken on any ref_tc_valid
// - three aux outputs each select a source, one being linear timecode
module tcg_timecode_gen #(
	parameter logic [4:0] FRAME_RATE = tcg_pkg::TCG_FRAME_RATE_DEF,
	parameter int LTC_HALF_DIV = 5
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// video timing
	input wire logic frame_start,
	input wire logic line_start,
	input wire logic [9:0] line_number,
	// reference timecode, decoded on the reference line
	input wire logic ref_tc_valid,
	input wire tcg_pkg::tcg_time_t ref_tc,
	// control
	input wire tcg_pkg::generator_run_mode_t generator_run_mode,
	input wire logic drop_frame_en,
	input wire logic preset_load,
	input wire tcg_pkg::tcg_time_t preset_time,
	input wire logic [2:0] composite_timecode_lines,
	input wire logic [2:0] serial_digital_timecode_lines,
	input wire logic [4:0] reference_timecode_line,
	input wire logic [3:0] aux_source_sel [tcg_pkg::TCG_AUX_COUNT],
	input wire logic [tcg_pkg::TCG_AUX_COUNT-1:0] aux_other_src,
	// outputs
	output tcg_pkg::tcg_time_t tc_count,
	output logic composite_insert,
	output logic serial_digital_insert,
	output logic ref_line_strobe,
	output logic [tcg_pkg::TCG_AUX_COUNT-1:0] aux_out
);
	tcg_pkg::tcg_time_t tc_q, tc_d, ref_q, ref_d;
	logic jam_done_q, jam_done_d;
	logic ref_ok_q, ref_ok_d;
	logic cins_q, cins_d, sins_q, sins_d, rstb_q, rstb_d;
	logic [tcg_pkg::TCG_AUX_COUNT-1:0] aux_q, aux_d;
	logic [7:0] div_q, div_d;
	logic bit_tick, ltc_line, frame_tick;

	function automatic tcg_pkg::tcg_time_t clamp_time(input tcg_pkg::tcg_time_t t);
		clamp_time = t;
		if (t.hours > tcg_pkg::TCG_HOURS_MAX) clamp_time.hours = tcg_pkg::TCG_HOURS_MAX;
		if (t.minutes > tcg_pkg::TCG_MINSEC_MAX) clamp_time.minutes = tcg_pkg::TCG_MINSEC_MAX;
		if (t.seconds > tcg_pkg::TCG_MINSEC_MAX) clamp_time.seconds = tcg_pkg::TCG_MINSEC_MAX;
		if (t.frames >= FRAME_RATE) clamp_time.frames = FRAME_RATE - 5'h01;
	endfunction

	function automatic tcg_pkg::tcg_time_t advance(input tcg_pkg::tcg_time_t t, input logic df);
		advance = t;
		if (t.frames != FRAME_RATE - 5'h01) begin
			advance.frames = t.frames + 5'h01;
		end else begin
			advance.frames = '0;
			if (t.seconds != tcg_pkg::TCG_MINSEC_MAX) begin
				advance.seconds = t.seconds + 6'h01;
			end else begin
				advance.seconds = '0;
				if (t.minutes != tcg_pkg::TCG_MINSEC_MAX) begin
					advance.minutes = t.minutes + 6'h01;
				end else begin
					advance.minutes = '0;
					advance.hours = (t.hours == tcg_pkg::TCG_HOURS_MAX) ? 5'h00 : t.hours + 5'h01;
				end
				// new minute: skip the first frame numbers unless a tenth minute
				if (df && (advance.minutes % 6'(tcg_pkg::TCG_DROP_SKIP_DIV)) != 6'h00) begin
					advance.frames = tcg_pkg::TCG_DROP_COUNT;
				end
			end
		end
	endfunction

	// true when the line is the first or second line of the selected pair
	function automatic logic on_pair(input logic [2:0] sel, input logic [9:0] ln);
		logic [9:0] first;
		first = 10'(tcg_pkg::TCG_INS_BASE_LINE) + 10'(sel);
		on_pair = (sel != 3'h0) && (ln == first || ln == first + 10'(tcg_pkg::TCG_PAIR_GAP));
	endfunction

	assign frame_tick = frame_start;

	always_comb begin
		tc_d = tc_q;
		jam_done_d = jam_done_q;
		ref_d = ref_q;
		ref_ok_d = ref_ok_q;
		if (ref_tc_valid) begin
			ref_d = clamp_time(ref_tc);
			ref_ok_d = 1'b1;
		end
		if (generator_run_mode != tcg_pkg::GENERATOR_RUN_MODE_JAM) begin
			jam_done_d = 1'b0;
		end
		if (preset_load) begin
			tc_d = clamp_time(preset_time);
		end else if (frame_tick) begin
			case (generator_run_mode)
				tcg_pkg::GENERATOR_RUN_MODE_RUN: tc_d = advance(tc_q, drop_frame_en);
				tcg_pkg::GENERATOR_RUN_MODE_TRACK: begin
					if (ref_ok_q) tc_d = ref_q;
				end
				tcg_pkg::GENERATOR_RUN_MODE_JAM: begin
					if (!jam_done_q && ref_ok_q) begin
						tc_d = ref_q;
						jam_done_d = 1'b1;
					end else begin
						tc_d = advance(tc_q, drop_frame_en);
					end
				end
				tcg_pkg::GENERATOR_RUN_MODE_HOLD: tc_d = tc_q;
				default: tc_d = tc_q;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			tc_q <= tcg_pkg::TCG_TIME_RESET;
			ref_q <= tcg_pkg::TCG_TIME_RESET;
			ref_ok_q <= 1'b0;
			jam_done_q <= 1'b0;
		end else begin
			tc_q <= tc_d;
			ref_q <= ref_d;
			ref_ok_q <= ref_ok_d;
			jam_done_q <= jam_done_d;
		end
	end

	// line strobes, registered so they line up with the count
	always_comb begin
		cins_d = line_start && on_pair(composite_timecode_lines, line_number);
		sins_d = line_start && on_pair(serial_digital_timecode_lines, line_number);
		rstb_d = line_start && reference_timecode_line >= tcg_pkg::TCG_REF_LINE_MIN
			&& reference_timecode_line <= tcg_pkg::TCG_REF_LINE_MAX
			&& line_number == 10'(reference_timecode_line);
		div_d = (frame_tick || div_q == 8'(LTC_HALF_DIV - 1)) ? 8'h00 : div_q + 8'h01;
		for (int i = 0; i < tcg_pkg::TCG_AUX_COUNT; i++) begin
			aux_d[i] = (aux_source_sel[i] == tcg_pkg::TCG_AUX_SRC_LTC) ? ltc_line : aux_other_src[i];
		end
	end

	assign bit_tick = (div_q == 8'(LTC_HALF_DIV - 1));

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cins_q <= 1'b0;
			sins_q <= 1'b0;
			rstb_q <= 1'b0;
			div_q <= 8'h00;
			aux_q <= '0;
		end else begin
			cins_q <= cins_d;
			sins_q <= sins_d;
			rstb_q <= rstb_d;
			div_q <= div_d;
			aux_q <= aux_d;
		end
	end

	tcg_ltc_ser u_ltc (
		.core_clk(core_clk),
		.reset(reset),
		.frame_tick(frame_tick),
		.bit_tick(bit_tick),
		.tc(tc_q),
		.ltc_out(ltc_line)
	);

	assign tc_count = tc_q;
	assign composite_insert = cins_q;
	assign serial_digital_insert = sins_q;
	assign ref_line_strobe = rstb_q;
	assign aux_out = aux_q;

	property p_reset_zero;
		@(posedge core_clk) $past(reset) && !reset |-> tc_q == tcg_pkg::TCG_TIME_RESET;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("count not zero after reset");

	property p_preset;
		@(posedge core_clk) disable iff (reset)
		preset_load && preset_time.hours <= tcg_pkg::TCG_HOURS_MAX |=> tc_q.hours == $past(preset_time.hours);
	endproperty
	a_preset: assert property (p_preset) else $error("preset not loaded");

	property p_range;
		@(posedge core_clk) disable iff (reset)
		tc_q.hours <= tcg_pkg::TCG_HOURS_MAX && tc_q.minutes <= tcg_pkg::TCG_MINSEC_MAX
			&& tc_q.seconds <= tcg_pkg::TCG_MINSEC_MAX;
	endproperty
	a_range: assert property (p_range) else $error("field out of range");

	property p_track;
		@(posedge core_clk) disable iff (reset)
		frame_tick && !preset_load && generator_run_mode == tcg_pkg::GENERATOR_RUN_MODE_TRACK && ref_ok_q |=> tc_q == $past(ref_q);
	endproperty
	a_track: assert property (p_track) else $error("track did not copy reference");

	property p_hold;
		@(posedge core_clk) disable iff (reset)
		!preset_load && generator_run_mode == tcg_pkg::GENERATOR_RUN_MODE_HOLD |=> $stable(tc_q);
	endproperty
	a_hold: assert property (p_hold) else $error("hold changed count");

	property p_drop;
		@(posedge core_clk) disable iff (reset)
		$past(drop_frame_en) && $changed(tc_q.minutes) && tc_q.minutes % 6'h0a != 6'h00
			&& $past(generator_run_mode) == tcg_pkg::GENERATOR_RUN_MODE_RUN && !$past(preset_load) |-> tc_q.frames == 5'h02;
	endproperty
	a_drop: assert property (p_drop) else $error("drop frame not skipped");

	property p_comp;
		@(posedge core_clk) disable iff (reset)
		composite_insert |-> $past(line_start) && $past(composite_timecode_lines) != 3'h0
			&& ($past(line_number) == 10'h00c + 10'($past(composite_timecode_lines))
			|| $past(line_number) == 10'h00e + 10'($past(composite_timecode_lines)));
	endproperty
	a_comp: assert property (p_comp) else $error("composite insert while off");

	property p_sdi;
		@(posedge core_clk) disable iff (reset)
		line_start && line_number == 10'h00d && serial_digital_timecode_lines == 3'h1 |=> serial_digital_insert;
	endproperty
	a_sdi: assert property (p_sdi) else $error("serial insert missed");

	property p_refl;
		@(posedge core_clk) disable iff (reset)
		ref_line_strobe |-> $past(line_start) && $past(line_number) == 10'($past(reference_timecode_line))
			&& $past(line_number) >= 10'h00c && $past(line_number) <= 10'h015;
	endproperty
	a_refl: assert property (p_refl) else $error("reference line out of range");

	property p_wrap;
		@(posedge core_clk) disable iff (reset)
		frame_tick && !preset_load && generator_run_mode == tcg_pkg::GENERATOR_RUN_MODE_RUN && tc_q.hours == 5'h17
			&& tc_q.minutes == 6'h3b && tc_q.seconds == 6'h3b && tc_q.frames == FRAME_RATE - 5'h01 |=> tc_q.hours == 5'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("hours did not wrap");
endmodule // tcg_timecode_gen
`default_nettype wire

// ---- tb/tcg_ref_src.sv ----
`timescale 1ns/10ps
`default_nettype none
// reference video source: frame and line timing plus the decoded reference time
module tcg_ref_src #(
	parameter int LINES = 24,
	parameter int LINE_LEN = 4,
	parameter int TC_LINE = 10
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// time carried on the reference
	input wire tcg_pkg::tcg_time_t ref_time,
	// timing and decoded time
	output logic frame_start,
	output logic line_start,
	output logic [9:0] line_number,
	output logic ref_tc_valid,
	output tcg_pkg::tcg_time_t ref_tc
);
	int pix;
	int lin;
	logic tc_now;
	assign tc_now = !reset && pix == 0 && lin == TC_LINE;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pix <= 0;
			lin <= 1;
		end else begin
			pix <= (pix == LINE_LEN - 1) ? 0 : pix + 1;
			if (pix == LINE_LEN - 1)
				lin <= (lin == LINES) ? 1 : lin + 1;
		end
	end
	always_ff @(posedge core_clk) begin
		line_start <= !reset && pix == 0;
		frame_start <= !reset && pix == 0 && lin == 1;
		line_number <= lin[9:0];
		ref_tc_valid <= tc_now;
		// outside the decode pulse the time bus no longer holds its value
		ref_tc <= (reset || tc_now) ? ref_time : ~ref_tc;
	end
endmodule // tcg_ref_src
`default_nettype wire

// ---- tb/test_timecode_generator.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_timecode_generator;
	typedef struct {tcg_pkg::tcg_time_t p, e; logic [1:0] f;} tcg_row_t;
	logic core_clk = 1'b0, reset = 1'b1, preset_load = 1'b0, drop_frame_en = 1'b0, aux_prev = 1'b0;
	logic frame_start, line_start, ref_tc_valid, composite_insert, serial_digital_insert, ref_line_strobe;
	logic [9:0] line_number;
	logic [2:0] comp_sel = 3'h0, sdi_sel = 3'h0, aux_other = 3'h0, aux_out, ins;
	logic [4:0] ref_line = 5'h0c;
	logic [3:0] aux_sel [3] = '{default: 4'h0};
	tcg_pkg::generator_run_mode_t mode = tcg_pkg::GENERATOR_RUN_MODE_RUN;
	tcg_pkg::tcg_time_t preset_time = '0, ref_time = '0, ref_tc, tc_count;
	int err_count = 0, n_tests = 0, last_line = 0, aux_flips = 0, ins_sum[3], ins_cnt[3];
	tcg_row_t rows[8];

	tcg_ref_src tcg_ref_src_i (.core_clk, .reset, .ref_time, .frame_start, .line_start, .line_number,
		.ref_tc_valid, .ref_tc);
	tcg_timecode_gen tcg_timecode_gen_i (.core_clk, .reset, .frame_start, .line_start, .line_number,
		.ref_tc_valid, .ref_tc, .generator_run_mode(mode), .drop_frame_en, .preset_load, .preset_time,
		.composite_timecode_lines(comp_sel), .serial_digital_timecode_lines(sdi_sel),
		.reference_timecode_line(ref_line), .aux_source_sel(aux_sel), .aux_other_src(aux_other),
		.tc_count, .composite_insert, .serial_digital_insert, .ref_line_strobe, .aux_out);

	initial forever #20 core_clk = ~core_clk;
	assign ins = {ref_line_strobe, serial_digital_insert, composite_insert};
	// pulses arrive one cycle after line_start, so pair them with the line seen before
	always @(posedge core_clk) begin
		for (int i = 0; i < 3; i++)
			if (ins[i]) begin
				ins_sum[i] += last_line;
				ins_cnt[i]++;
			end
		if (line_start)
			last_line = int'(line_number);
		aux_flips += aux_out[1] ^ aux_prev;
		aux_prev = aux_out[1];
	end

	task automatic check(input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	function automatic tcg_pkg::tcg_time_t mk(input int h, m, s, f);
		return {h[4:0], m[5:0], s[5:0], f[4:0]};
	endfunction
	// reads at an edge see the values settled after the edge before it
	task automatic frame(input int n);
		repeat (n) begin
			@(posedge core_clk);
			for (int i = 0; i < 200 && !frame_start; i++)
				@(posedge core_clk);
		end
		repeat (2) @(posedge core_clk);
	endtask
	task automatic preset(input tcg_pkg::tcg_time_t t);
		@(posedge core_clk);
		preset_load <= 1'b1;
		preset_time <= t;
		@(posedge core_clk);
		preset_load <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	initial begin
		#1000000;
		err_count++;
		report_and_stop();
	end

	initial begin
		rows = '{'{mk(0,0,0,5), mk(0,0,0,6), 2'h0}, '{mk(0,0,0,29), mk(0,0,1,0), 2'h0},
			'{mk(0,0,59,29), mk(0,1,0,0), 2'h0}, '{mk(0,59,59,29), mk(1,0,0,0), 2'h0},
			'{mk(23,59,59,29), mk(0,0,0,0), 2'h0}, '{mk(0,0,59,29), mk(0,1,0,2), 2'h1},
			'{mk(0,9,59,29), mk(0,10,0,0), 2'h1}, '{mk(1,2,3,4), mk(1,2,3,4), 2'h2}};
		repeat (3) @(posedge core_clk);
		reset <= 0;
		@(posedge core_clk);
		check(tc_count, 0);
		check({ins, aux_out}, 0);
		frame(1);
		check(tc_count, mk(0,0,0,1));
		$display("reset test done");
		foreach (rows[i]) begin
			drop_frame_en <= rows[i].f[0];
			mode <= rows[i].f[1] ? tcg_pkg::GENERATOR_RUN_MODE_HOLD : tcg_pkg::GENERATOR_RUN_MODE_RUN;
			preset(rows[i].p);
			check(tc_count, rows[i].p);
			frame(1);
			check(tc_count, rows[i].e);
			$display("row %0d done", i);
		end
		preset(mk(31,63,63,31));
		check(tc_count, mk(23,59,59,29));
		$display("clamp test done");
		for (int k = 0; k < 11; k++) begin
			comp_sel <= 3'(k % 8);
			sdi_sel <= 3'((k + 3) % 8);
			ref_line <= 5'(12 + k);
			frame(1);
			ins_sum = '{0, 0, 0};
			ins_cnt = '{0, 0, 0};
			frame(1);
			check(ins_cnt[0] * 256 + ins_sum[0], (k % 8) ? 512 + 26 + 2 * (k % 8) : 0);
			check(ins_cnt[1] * 256 + ins_sum[1], ((k + 3) % 8) ? 512 + 26 + 2 * ((k + 3) % 8) : 0);
			check(ins_cnt[2] * 256 + ins_sum[2], (k < 10) ? 256 + 12 + k : 0);
		end
		$display("line select test done");
		aux_sel <= '{4'h1, 4'h0, 4'h1};
		aux_other <= 3'h7;
		repeat (3) @(posedge core_clk);
		check(aux_out & 3'h5, 3'h5);
		aux_other <= 3'h0;
		aux_flips = 0;
		frame(2);
		check(aux_out & 3'h5, 3'h0);
		check(aux_flips > 4, 1);
		$display("aux test done");
		ref_time <= mk(10,20,30,15);
		mode <= tcg_pkg::GENERATOR_RUN_MODE_TRACK;
		frame(2);
		check(tc_count, mk(10,20,30,15));
		ref_time <= mk(3,4,5,6);
		frame(2);
		check(tc_count, mk(3,4,5,6));
		mode <= tcg_pkg::GENERATOR_RUN_MODE_JAM;
		ref_time <= mk(0,0,10,0);
		frame(2);
		ref_time <= mk(9,9,9,9);
		frame(1);
		check(tc_count, mk(0,0,10,2));
		$display("track and jam test done");
		// mid-run reset must clear the count and every strobe, then count onward
		mode <= tcg_pkg::GENERATOR_RUN_MODE_RUN;
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		check(tc_count, 32'h0);
		check({ins, aux_out}, 32'h0);
		frame(1);
		check(tc_count, mk(0,0,0,1));
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule // test_timecode_generator
`default_nettype wire
